// >>> pwr_seq_map.svh
// offsets, field positions, reset values and timing counts of the power-up sequencer
// Overview of operation
// - on power-up only, run a 72 ms supply settle time-out on the RC clock.
// - keep the core in reset while the supply settle timer runs.
// - settle_timer_disable_n 0 uses the timer, 1 skips it.
// - after supply settle, count 1024 oscillator input cycles before leaving reset.
// - oscillator count only in crystal modes, on power-on or sleep wake-up.
// - settle timer starts after the power-on pulse; oscillator count after it.
// - RC mode with settle timer disabled gives no power-up time-out.
// - time-outs run despite clear pin; execution starts when pin goes high.
// - power-on flag cleared by power-on reset, unchanged by all others.
// - power-on reset sets timeout and power-down flags to one.
// - cause flags follow watchdog, wake-up and external clear combinations.
// - resets load PC 000h; wake-ups PC+1, or 0004h on interrupt wake-up with interrupts enabled.
// - status resets 0001 1xxx on power-on; flags kept on clear in run.
// - working registers kept except power-on; PC low byte zero on resets.
// - watchdog wake-up resumes and leaves reset registers unchanged.
// - watchdog reset acts internally, never drives the clear pin low.
`ifndef PWR_SEQ_MAP_SVH
`define PWR_SEQ_MAP_SVH
`define PCS_OFS 8'h00
`define IRQ_STS_OFS 8'h04
`define IRQ_MSK_OFS 8'h08
`define SEQ_STATE_OFS 8'h0c
`define PCS_POR_BIT 1
`define IRQ_SETTLED_BIT 0
`define IRQ_WDT_BIT 1
`define IRQ_WAKE_BIT 2
`define IRQ_CLEAR_BIT 3
`define CORE_CLK_HZ 40000000
`define RC_CLK_HZ 1000000
`define RC_DIV (`CORE_CLK_HZ / `RC_CLK_HZ)
`define SETTLE_TIME_MS 72
`define SETTLE_TICKS (`SETTLE_TIME_MS * (`RC_CLK_HZ / 1000))
`define OSC_SETTLE_CYCLES 1024
`define PC_RESET 13'h0000
`define PC_IRQ_VEC 13'h0004
`endif

// >>> pwr_seq_pkg.sv
// types of the power-up sequencer
package pwr_seq_pkg;
  typedef enum logic [1:0] {ST_SUPPLY, ST_OSC_POR, ST_OSC_WAKE, ST_RUN} seq_state_t;
  typedef enum logic [2:0] {RK_NONE, RK_POR, RK_CLEAR, RK_WDT, RK_WAKE} reset_kind_t;
  typedef enum logic [1:0] {OSC_LP, OSC_XT, OSC_HS, OSC_RC} osc_mode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    seq_state_t st;
    logic [19:0] cnt;
    logic [7:0] div;
    logic osc_q;
    logic pin_q;
    logic power_control_status_por;
    logic to_n;
    logic pd_n;
    logic [3:0] sts;
    logic [3:0] msk;
    logic [7:0] rdata;
    reset_kind_t kind;
    logic pc_load;
    logic [12:0] pc_val;
    logic wdt_rst;
  } seq_regs_t;
endpackage

// >>> power_up_reset_sequencer.sv
// power-up reset sequencer: settle timers, reset cause flags, pc load
`timescale 1ns/1ps
`include "pwr_seq_map.svh"
module power_up_reset_sequencer import pwr_seq_pkg::*; #(
  parameter int unsigned RC_DIV = `RC_DIV,
  parameter int unsigned SETTLE_TICKS = `SETTLE_TICKS,
  parameter int unsigned OSC_CYCLES = `OSC_SETTLE_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // power and pins
  input wire logic power_on_pulse_i,
  input wire logic external_clear_pin_i,
  input wire logic osc_input_pin_i,
  // configuration
  input wire logic settle_timer_disable_n_i,
  input wire osc_mode_t osc_mode_i,
  // core status
  input wire logic sleeping_i,
  input wire logic watchdog_timeout_i,
  input wire logic irq_wake_i,
  input wire logic global_irq_enable_i,
  input wire logic [12:0] current_pc_i,
  // register port
  input wire reg_req_t req_i,
  output logic [7:0] rdata_o,
  // core control
  output logic core_reset_o,
  output reset_kind_t reset_kind_o,
  output logic pc_load_o,
  output logic [12:0] pc_value_o,
  output logic watchdog_timeout_flag_n_o,
  output logic powerdown_flag_n_o,
  output logic irq_o
);
  seq_regs_t q;
  seq_regs_t d;
  logic rc_tick;
  logic osc_edge;
  logic clr_fall;
  logic crystal;
  logic [3:0] ev;

  function automatic logic hit(input reg_req_t r, input logic [7:0] ofs);
    hit = r.addr == ofs;
  endfunction

  // internal rc clock as an enable pulse from the core clock
  assign rc_tick = q.div == 8'(RC_DIV - 1);
  assign osc_edge = osc_input_pin_i & ~q.osc_q;
  assign clr_fall = q.pin_q & ~external_clear_pin_i;
  assign crystal = osc_mode_i != OSC_RC;

  always_comb begin
    d = q;
    ev = 4'h0;
    d.pc_load = 1'b0;
    d.wdt_rst = 1'b0;
    d.kind = RK_NONE;
    d.rdata = 8'h00;
    d.osc_q = osc_input_pin_i;
    d.pin_q = external_clear_pin_i;
    d.div = rc_tick ? 8'h00 : q.div + 8'h01;
    case (q.st)
      ST_SUPPLY: begin
        // skip when disabled, else count rc ticks
        if (settle_timer_disable_n_i || (rc_tick && q.cnt == 20'(SETTLE_TICKS - 1))) begin
          d.cnt = 20'h0;
          d.st = crystal ? ST_OSC_POR : ST_RUN;
          ev[`IRQ_SETTLED_BIT] = !crystal;
        end else if (rc_tick) begin
          d.cnt = q.cnt + 20'h1;
        end
      end
      ST_OSC_POR, ST_OSC_WAKE: begin
        // count oscillator input edges
        if (osc_edge) begin
          if (q.cnt == 20'(OSC_CYCLES - 1)) begin
            d.cnt = 20'h0;
            d.st = ST_RUN;
            if (q.st == ST_OSC_WAKE) begin
              d.pc_load = 1'b1;
              d.kind = RK_WAKE;
              ev[`IRQ_WAKE_BIT] = 1'b1;
            end else begin
              ev[`IRQ_SETTLED_BIT] = 1'b1;
            end
          end else begin
            d.cnt = q.cnt + 20'h1;
          end
        end
      end
      ST_RUN: begin
        if (sleeping_i && (watchdog_timeout_i || irq_wake_i)) begin
          // wake-up: resume, registers untouched
          d.to_n = !watchdog_timeout_i;
          d.pd_n = 1'b0;
          d.pc_val = (!watchdog_timeout_i && global_irq_enable_i) ? `PC_IRQ_VEC
                     : current_pc_i + 13'h1;
          if (crystal) begin
            d.st = ST_OSC_WAKE;
            d.cnt = 20'h0;
          end else begin
            d.pc_load = 1'b1;
            d.kind = RK_WAKE;
            ev[`IRQ_WAKE_BIT] = 1'b1;
          end
        end else if (watchdog_timeout_i) begin
          // internal reset only, clear pin not driven
          d.to_n = 1'b0;
          d.pd_n = 1'b1;
          d.wdt_rst = 1'b1;
          d.pc_load = 1'b1;
          d.pc_val = `PC_RESET;
          d.kind = RK_WDT;
          ev[`IRQ_WDT_BIT] = 1'b1;
        end
      end
      default: d.st = ST_RUN;
    endcase
    // external clear: flags kept in run, sleep gives to 1 pd 0
    if (clr_fall && q.st != ST_SUPPLY && q.st != ST_OSC_POR) begin
      if (sleeping_i || q.st == ST_OSC_WAKE) begin
        d.to_n = 1'b1;
        d.pd_n = 1'b0;
      end else begin
        d.to_n = q.to_n;
        d.pd_n = q.pd_n;
      end
      d.st = ST_RUN;
      d.wdt_rst = 1'b0;
      d.pc_load = 1'b1;
      d.pc_val = `PC_RESET;
      d.kind = RK_CLEAR;
      ev = 4'h0;
      ev[`IRQ_CLEAR_BIT] = 1'b1;
    end
    // software sets the power-on flag
    if (req_i.wr && hit(req_i, `PCS_OFS)) begin
      d.power_control_status_por = req_i.wdata[`PCS_POR_BIT];
    end
    if (req_i.wr && hit(req_i, `IRQ_MSK_OFS)) begin
      d.msk = req_i.wdata[3:0];
    end
    // power-on pulse restarts the sequence, counting begins when it ends
    if (power_on_pulse_i) begin
      d.st = ST_SUPPLY;
      d.cnt = 20'h0;
      d.power_control_status_por = 1'b0;
      d.to_n = 1'b1;
      d.pd_n = 1'b1;
      d.wdt_rst = 1'b0;
      d.pc_load = 1'b1;
      d.pc_val = `PC_RESET;
      d.kind = RK_POR;
      ev = 4'h0;
    end
    // write one to clear, a new event wins
    if (req_i.wr && hit(req_i, `IRQ_STS_OFS)) begin
      d.sts = q.sts & ~req_i.wdata[3:0];
    end
    d.sts = d.sts | ev;
    if (req_i.rd) begin
      case (req_i.addr)
        `PCS_OFS: d.rdata = {6'h00, q.power_control_status_por, 1'b0};
        `IRQ_STS_OFS: d.rdata = {4'h0, q.sts};
        `IRQ_MSK_OFS: d.rdata = {4'h0, q.msk};
        `SEQ_STATE_OFS: d.rdata = {q.to_n, q.pd_n, 4'h0, q.st};
        default: d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '{st: ST_SUPPLY, cnt: 20'h0, div: 8'h00, osc_q: 1'b0, pin_q: 1'b1,
             power_control_status_por: 1'b0, to_n: 1'b1, pd_n: 1'b1, sts: 4'h0, msk: 4'h0,
             rdata: 8'h00, kind: RK_POR, pc_load: 1'b0, pc_val: `PC_RESET,
             wdt_rst: 1'b0};
    end else begin
      q <= d;
    end
  end

  // hold core during power-up timers, clear pin low, or watchdog reset
  assign core_reset_o = q.st == ST_SUPPLY || q.st == ST_OSC_POR || !external_clear_pin_i
                        || q.wdt_rst;
  assign rdata_o = q.rdata;
  assign reset_kind_o = q.kind;
  assign pc_load_o = q.pc_load;
  assign pc_value_o = q.pc_val;
  assign watchdog_timeout_flag_n_o = q.to_n;
  assign powerdown_flag_n_o = q.pd_n;
  assign irq_o = |(q.sts & q.msk);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_quiet;
    !power_on_pulse_i && !clr_fall;
  endsequence
  sequence s_wdt_run;
    q.st == ST_RUN && !sleeping_i && watchdog_timeout_i ##0 s_quiet;
  endsequence
  sequence s_irq_wake_rc;
    q.st == ST_RUN && sleeping_i && irq_wake_i && !watchdog_timeout_i
      && global_irq_enable_i && osc_mode_i == OSC_RC ##0 s_quiet;
  endsequence

  chk_supply_holds_core: assert property (
    q.st == ST_SUPPLY |-> core_reset_o) else $error("core not held during settle");
  chk_settle_skip: assert property (
    (q.st == ST_SUPPLY && settle_timer_disable_n_i && !power_on_pulse_i)
      |=> q.st != ST_SUPPLY) else $error("disabled settle timer not skipped");
  chk_rc_no_osc: assert property (
    (q.st == ST_SUPPLY && osc_mode_i == OSC_RC && !power_on_pulse_i)
      |=> q.st != ST_OSC_POR) else $error("oscillator count in rc mode");
  chk_osc_waits_edge: assert property (
    (q.st == ST_OSC_POR && !osc_edge && !power_on_pulse_i) |=> q.st == ST_OSC_POR)
    else $error("oscillator count left without edge");
  chk_por_flags_set: assert property (
    power_on_pulse_i |=> !q.power_control_status_por && q.to_n && q.pd_n && q.st == ST_SUPPLY)
    else $error("power-on flags wrong");
  chk_por_flag_keep: assert property (
    (!power_on_pulse_i && !(req_i.wr && req_i.addr == `PCS_OFS)) |=> $stable(q.power_control_status_por))
    else $error("power-on flag changed");
  chk_wdt_reset_flags: assert property (
    s_wdt_run |=> !q.to_n && q.pd_n && q.pc_load && q.pc_val == `PC_RESET
      && q.wdt_rst ##1 !q.wdt_rst) else $error("watchdog reset flags wrong");
  chk_irq_wake_vector: assert property (
    s_irq_wake_rc |=> q.pc_load && q.pc_val == `PC_IRQ_VEC && q.to_n && !q.pd_n)
    else $error("interrupt wake vector wrong");
  chk_clear_run_keep: assert property (
    (clr_fall && q.st == ST_RUN && !sleeping_i && !power_on_pulse_i)
      |=> q.kind == RK_CLEAR && $stable(q.to_n) && $stable(q.pd_n))
    else $error("clear in run changed flags");
  chk_release_runs: assert property (
    (q.st == ST_RUN && external_clear_pin_i && !q.wdt_rst) |-> !core_reset_o)
    else $error("core held after release");
endmodule

// >>> pin_osc_model.sv
// far-side model: clear pin driver and crystal input
`timescale 1ns/1ps
module pin_osc_model (
  // clock
  input wire logic clk_i,
  // commands
  input wire logic hold_clear_i,
  input wire logic osc_run_i,
  // pins
  output logic clear_pin_o,
  output logic osc_o
);
  // pull-up: pin high unless held low
  assign clear_pin_o = !hold_clear_i;
  initial osc_o = 1'b0;
  // crystal stands still until started
  always @(posedge clk_i) begin
    if (osc_run_i) begin
      osc_o <= !osc_o;
    end
  end
endmodule

// >>> power_up_reset_sequencer_tb.sv
// self-checking bench of the power-up reset sequencer
`timescale 1ns/1ps
module power_up_reset_sequencer_tb import pwr_seq_pkg::*;;
  logic core_clk_i = 0, reset_n_i = 0, hold = 1, run = 0, dis = 0;
  logic sl = 0, wdt = 0, wk = 0, global_irq_enable = 0, por = 0, pin, osc;
  osc_mode_t mode_list [3] = '{OSC_LP, OSC_HS, OSC_RC};
  osc_mode_t mode = OSC_XT;
  reg_req_t req_i = '0;
  logic [7:0] rdata_o;
  logic core_reset_o, pc_load_o, to_n, pd_n, irq_o;
  logic [12:0] pc_value_o, lv;
  reset_kind_t kind_o, lk;
  int n_fail = 0, cmp_count = 0;
  always #12.5 core_clk_i = !core_clk_i;
  pin_osc_model model (.clk_i(core_clk_i), .hold_clear_i(hold), .osc_run_i(run),
    .clear_pin_o(pin), .osc_o(osc));
  power_up_reset_sequencer #(.RC_DIV(2), .SETTLE_TICKS(10), .OSC_CYCLES(4)) dut (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .power_on_pulse_i(por),
    .external_clear_pin_i(pin), .osc_input_pin_i(osc), .settle_timer_disable_n_i(dis),
    .osc_mode_i(mode), .sleeping_i(sl), .watchdog_timeout_i(wdt), .irq_wake_i(wk),
    .global_irq_enable_i(global_irq_enable), .current_pc_i(13'h0123), .req_i(req_i), .rdata_o(rdata_o),
    .core_reset_o(core_reset_o), .reset_kind_o(kind_o), .pc_load_o(pc_load_o),
    .pc_value_o(pc_value_o), .watchdog_timeout_flag_n_o(to_n),
    .powerdown_flag_n_o(pd_n), .irq_o(irq_o));
  always @(posedge core_clk_i) begin
    if (pc_load_o === 1'b1) begin
      lk <= kind_o;
      lv <= pc_value_o;
    end
  end
  task chk(input logic [12:0] seen, input logic [12:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i) req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i) req_i <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i) req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i) req_i <= '0;
    @(negedge core_clk_i) chk(13'(rdata_o), 13'(e));
  endtask
  task boot(input osc_mode_t m, input logic d);
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    mode <= m;
    dis <= d;
    run <= 1'b0;
    repeat (20) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
  endtask
  // one event: clear pin, watchdog, wake, sleeping
  task ev(input logic c, input logic w, input logic i, input logic s);
    @(posedge core_clk_i) {hold, wdt, wk, sl} <= {c, w, i, s};
    @(posedge core_clk_i) {wdt, wk} <= 2'b00;
    @(posedge core_clk_i) hold <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    sl <= 1'b0;
  endtask
  task res(input logic t, input logic p, input reset_kind_t k, input logic [12:0] v);
    @(negedge core_clk_i) chk(13'({to_n, pd_n}), 13'({t, p}));
    chk(13'(lk), 13'(k));
    chk(lv, v);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    final_report();
  end
  initial begin
    // power-up, crystal, timer used, clear pin held
    boot(OSC_XT, 1'b0);
    rd(8'h00, 8'h00);
    rd(8'h0c, 8'hc0);
    repeat (40) @(posedge core_clk_i);
    @(negedge core_clk_i) chk(13'(core_reset_o), 13'h1);
    rd(8'h0c, 8'hc1);
    @(posedge core_clk_i) run <= 1'b1;
    repeat (30) @(posedge core_clk_i);
    rd(8'h0c, 8'hc3);
    chk(13'(core_reset_o), 13'h1);
    @(posedge core_clk_i) hold <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i) chk(13'(core_reset_o), 13'h0);
    $display("power-up done");
    // software sets the power-on flag; irq path
    wr(8'h00, 8'h02);
    rd(8'h00, 8'h02);
    rd(8'h10, 8'h00);
    rd(8'h04, 8'h01);
    chk(13'(irq_o), 13'h0);
    wr(8'h08, 8'h01);
    @(negedge core_clk_i) chk(13'(irq_o), 13'h1);
    wr(8'h04, 8'h01);
    rd(8'h04, 8'h00);
    chk(13'(irq_o), 13'h0);
    $display("registers done");
    // reset causes and pc loads
    @(posedge core_clk_i) mode <= OSC_RC;
    global_irq_enable <= 1'b1;
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    res(1'b1, 1'b1, RK_CLEAR, 13'h0000);
    ev(1'b0, 1'b1, 1'b0, 1'b0);
    res(1'b0, 1'b1, RK_WDT, 13'h0000);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    res(1'b0, 1'b1, RK_CLEAR, 13'h0000);
    ev(1'b0, 1'b0, 1'b1, 1'b1);
    res(1'b1, 1'b0, RK_WAKE, 13'h0004);
    @(posedge core_clk_i) global_irq_enable <= 1'b0;
    ev(1'b0, 1'b1, 1'b0, 1'b1);
    res(1'b0, 1'b0, RK_WAKE, 13'h0124);
    ev(1'b1, 1'b0, 1'b0, 1'b1);
    res(1'b1, 1'b0, RK_CLEAR, 13'h0000);
    rd(8'h00, 8'h02);
    rd(8'h04, 8'h0e);
    $display("events done");
    // supply-rise pulse restarts the sequence
    @(posedge core_clk_i) por <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    por <= 1'b0;
    rd(8'h00, 8'h00);
    rd(8'h0c, 8'hc0);
    chk(13'(lk), 13'(RK_POR));
    chk(lv, 13'h0000);
    $display("power-on pulse done");
    // timer disabled: crystal modes still count, rc none
    foreach (mode_list[j]) begin
      boot(mode_list[j], 1'b1);
      repeat (10) @(posedge core_clk_i);
      @(negedge core_clk_i) chk(13'(core_reset_o), 13'(mode_list[j] != OSC_RC));
      @(posedge core_clk_i) run <= 1'b1;
      repeat (30) @(posedge core_clk_i);
      @(negedge core_clk_i) chk(13'(core_reset_o), 13'h0);
    end
    $display("modes done");
    final_report();
  end
endmodule
